// ### core/oim_consts.svh
/*
  Offsets, field positions, reset values and timing counts of the
  oversampled IIR measurement block.
  Assumes a 32-bit AXI4-Lite bus with byte addresses and a 10 MHz clock.
*/
`ifndef OIM_CONSTS_SVH
`define OIM_CONSTS_SVH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define OIM_ADDR_W 8
`define OIM_REG_POWER_CONTROL 8'h00
`define OIM_REG_OSR 8'h04
`define OIM_REG_CONFIG 8'h08
`define OIM_REG_STATUS 8'h0c
`define OIM_REG_PRESS_DATA 8'h10
`define OIM_REG_TEMP_DATA 8'h14

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define OIM_PC_PRESS_EN 0
`define OIM_PC_TEMP_EN 1
`define OIM_PC_MODE_LO 4
`define OIM_OSR_P_LO 0
`define OIM_OSR_T_LO 3
`define OIM_CFG_FILT_LO 1
`define OIM_MODE_SLEEP 2'h0
`define OIM_MODE_NORMAL 2'h3
`define OIM_OSR_MAX 3'h5
`define OIM_FILT_OFF 3'h0
`define OIM_BASE_BITS 5'h10
`define OIM_RESP_OKAY 2'h0
`define OIM_RESP_SLVERR 2'h2

// ****************************************************************
// Timing.
// ****************************************************************
`define OIM_CLK_NS 100
`define OIM_STANDBY_NS 5000000
`define OIM_STANDBY_CYCLES (`OIM_STANDBY_NS / `OIM_CLK_NS)

`endif

// ### core/oim_filter.sv
/*
  Measurement sequencer, resolution masking and IIR smoothing with an
  AXI4-Lite register slave.
  Assumes a converter on the same clock that takes conv_req and returns
  one conv_done pulse with the raw results, left aligned in 24 bits.
*/
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
// Behaviour
// - Temperature converts only while power control bit 1 is set.
// - Temperature oversampling field bits 5:3, codes 0..5 give 1..32 samples.
// - Each oversampling doubling adds one result bit, 16 up to 21 bits.
// - New output is old times coefficient plus raw, over coefficient plus one.
// - Filter coefficient comes from the configuration register field.
// - Any write to the coefficient setting resets the filter.
// - After a filter reset the first sample passes and seeds memory.
// - Either enable bit falling resets the filter.
// - Sleep to normal mode transition resets the filter.
// - Newly enabled channel passes its next value unfiltered as seed.
// - Mode field 00 sleep, 01 or 10 forced, 11 normal.
// - Pressure converts only while power control bit 0 is set.
// - Forced mode measures once then returns to sleep, results kept.
`timescale 1ns/10ps
`include "oim_consts.svh"

module oim_filter import oim_pkg::*; #(
  parameter int STANDBY_CYCLES = `OIM_STANDBY_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`OIM_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [`OIM_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic conv_req,
  output oim_conv_t conv_cfg,
  input wire logic conv_done,
  input wire logic [23:0] raw_press,
  input wire logic [23:0] raw_temp
);
  // ****************************************************************
  // Parameter check.
  // ****************************************************************
  // The standby counter is 24 bits wide and must load at least zero.
  if (STANDBY_CYCLES < 1 || STANDBY_CYCLES > 24'hff_ffff) begin : g_bad_standby
    $error("STANDBY_CYCLES out of range");
  end

  // ****************************************************************
  // Helper functions.
  // ****************************************************************
  // Keeps 16 plus osr significant bits; unused codes act as the top one.
  function automatic logic [23:0] res_mask(input logic [23:0] x, input logic [2:0] osr);
    logic [2:0] o;
    o = (osr > `OIM_OSR_MAX) ? `OIM_OSR_MAX : osr;
    res_mask = x & ~(24'hff_ffff >> (`OIM_BASE_BITS + {2'h0, o}));
  endfunction
  // Coefficient is 2^k - 1, so the divide by coefficient plus one is a shift.
  function automatic logic [23:0] iir(input logic [23:0] old, input logic [23:0] x,
                                      input logic [2:0] k);
    logic [31:0] acc;
    acc = (({8'h00, old} << k) - {8'h00, old}) + {8'h00, x};
    iir = 24'(acc >> k);
  endfunction

  // ****************************************************************
  // State.
  // ****************************************************************
  logic aw_held, next_aw_held;
  logic [`OIM_ADDR_W-1:0] aw_addr, next_aw_addr;
  logic w_held, next_w_held;
  logic [7:0] w_byte, next_w_byte;
  logic w_lane, next_w_lane;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic press_en, next_press_en;
  logic temp_en, next_temp_en;
  logic [1:0] pmode, next_pmode;
  logic [2:0] osr_p, next_osr_p;
  logic [2:0] osr_t, next_osr_t;
  logic [2:0] filt_code, next_filt_code;
  logic seed_p, next_seed_p;
  logic seed_t, next_seed_t;
  logic [23:0] press_data, next_press_data;
  logic [23:0] temp_data, next_temp_data;
  oim_state_t state, next_state;
  logic [23:0] cnt, next_cnt;
  logic req, next_req;
  oim_conv_t conv, next_conv;
  logic [23:0] xp, xt;
  logic [1:0] nm;
  // Handshake outputs are taken straight from the holding flags.
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  assign conv_req = req;
  assign conv_cfg = conv;

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  // Sequencer first, then bus writes, so a same-cycle filter reset keeps its seed flag.
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_byte = w_byte;
    next_w_lane = w_lane;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_press_en = press_en;
    next_temp_en = temp_en;
    next_pmode = pmode;
    next_osr_p = osr_p;
    next_osr_t = osr_t;
    next_filt_code = filt_code;
    next_seed_p = seed_p;
    next_seed_t = seed_t;
    next_press_data = press_data;
    next_temp_data = temp_data;
    next_state = state;
    next_cnt = cnt;
    next_req = req;
    next_conv = conv;
    xp = res_mask(raw_press, conv.osr_p);
    xt = res_mask(raw_temp, conv.osr_t);
    nm = w_byte[`OIM_PC_MODE_LO +: 2];
    // Measurement sequencer.
    case (state)
      ST_IDLE: begin
        if (pmode != `OIM_MODE_SLEEP) begin
          if (press_en || temp_en) begin
            next_conv.do_press = press_en;
            next_conv.do_temp = temp_en;
            next_conv.osr_p = osr_p;
            next_conv.osr_t = osr_t;
            next_req = 1'b1;
            next_state = ST_MEAS;
          end else if (pmode != `OIM_MODE_NORMAL) begin
            next_pmode = `OIM_MODE_SLEEP;
          end
        end
      end
      ST_MEAS: begin
        if (conv_done) begin
          next_req = 1'b0;
          // Each channel's memory moves only on its own conversion.
          if (conv.do_press) begin
            next_press_data = (seed_p || filt_code == `OIM_FILT_OFF) ? xp :
                              iir(press_data, xp, filt_code);
            next_seed_p = 1'b0;
          end
          if (conv.do_temp) begin
            next_temp_data = (seed_t || filt_code == `OIM_FILT_OFF) ? xt :
                             iir(temp_data, xt, filt_code);
            next_seed_t = 1'b0;
          end
          if (pmode == `OIM_MODE_NORMAL) begin
            next_state = ST_STANDBY;
            next_cnt = 24'(STANDBY_CYCLES - 1);
          end else begin
            next_state = ST_IDLE;
            next_pmode = `OIM_MODE_SLEEP;
          end
        end
      end
      ST_STANDBY: begin
        if (pmode != `OIM_MODE_NORMAL || cnt == 24'h00_0000) begin
          next_state = ST_IDLE;
        end else begin
          next_cnt = cnt - 24'h00_0001;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // Write address and data are taken independently, in either order.
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_byte = s_axi_wdata[7:0];
      next_w_lane = s_axi_wstrb[0];
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // Register write once both halves are in and no response is pending.
    if (aw_held && w_held && !bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `OIM_RESP_OKAY;
      if (aw_addr == `OIM_REG_POWER_CONTROL) begin
        if (w_lane) begin
          next_press_en = w_byte[`OIM_PC_PRESS_EN];
          next_temp_en = w_byte[`OIM_PC_TEMP_EN];
          next_pmode = nm;
          if (press_en != w_byte[`OIM_PC_PRESS_EN]) begin
            next_seed_p = 1'b1;
          end
          if (temp_en != w_byte[`OIM_PC_TEMP_EN]) begin
            next_seed_t = 1'b1;
          end
          // Any channel falling restarts both memories.
          if ((press_en && !w_byte[`OIM_PC_PRESS_EN]) ||
              (temp_en && !w_byte[`OIM_PC_TEMP_EN])) begin
            next_seed_p = 1'b1;
            next_seed_t = 1'b1;
          end
          if (pmode == `OIM_MODE_SLEEP && nm == `OIM_MODE_NORMAL) begin
            next_seed_p = 1'b1;
            next_seed_t = 1'b1;
          end
        end
      end else if (aw_addr == `OIM_REG_OSR) begin
        if (w_lane) begin
          next_osr_p = w_byte[`OIM_OSR_P_LO +: 3];
          next_osr_t = w_byte[`OIM_OSR_T_LO +: 3];
        end
      end else if (aw_addr == `OIM_REG_CONFIG) begin
        if (w_lane) begin
          next_filt_code = w_byte[`OIM_CFG_FILT_LO +: 3];
          next_seed_p = 1'b1;
          next_seed_t = 1'b1;
        end
      end else begin
        next_bresp = `OIM_RESP_SLVERR;
      end
    end
    // Reads answer one cycle after the address is taken.
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = `OIM_RESP_OKAY;
      if (s_axi_araddr == `OIM_REG_POWER_CONTROL) begin
        next_rdata = {26'h000_0000, pmode, 2'h0, temp_en, press_en};
      end else if (s_axi_araddr == `OIM_REG_OSR) begin
        next_rdata = {26'h000_0000, osr_t, osr_p};
      end else if (s_axi_araddr == `OIM_REG_CONFIG) begin
        next_rdata = {28'h000_0000, filt_code, 1'b0};
      end else if (s_axi_araddr == `OIM_REG_STATUS) begin
        next_rdata = {29'h000_0000, seed_t, seed_p, state != ST_IDLE};
      end else if (s_axi_araddr == `OIM_REG_PRESS_DATA) begin
        next_rdata = {8'h00, press_data};
      end else if (s_axi_araddr == `OIM_REG_TEMP_DATA) begin
        next_rdata = {8'h00, temp_data};
      end else begin
        next_rdata = 32'h0000_0000;
        next_rresp = `OIM_RESP_SLVERR;
      end
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    // Synchronous reset; the device wakes in sleep with memories seeded.
    if (!aresetn) begin
      next_aw_held = 1'b0;
      next_aw_addr = '0;
      next_w_held = 1'b0;
      next_w_byte = 8'h00;
      next_w_lane = 1'b0;
      next_bvalid = 1'b0;
      next_bresp = `OIM_RESP_OKAY;
      next_rvalid = 1'b0;
      next_rdata = 32'h0000_0000;
      next_rresp = `OIM_RESP_OKAY;
      next_press_en = 1'b0;
      next_temp_en = 1'b0;
      next_pmode = `OIM_MODE_SLEEP;
      next_osr_p = 3'h0;
      next_osr_t = 3'h0;
      next_filt_code = `OIM_FILT_OFF;
      next_seed_p = 1'b1;
      next_seed_t = 1'b1;
      next_press_data = 24'h00_0000;
      next_temp_data = 24'h00_0000;
      next_state = ST_IDLE;
      next_cnt = 24'h00_0000;
      next_req = 1'b0;
      next_conv = '0;
    end
  end
  // ****************************************************************
  // Registers.
  // ****************************************************************
  // Plain registering of every next value.
  always_ff @(posedge aclk) begin
    aw_held <= next_aw_held;
    aw_addr <= next_aw_addr;
    w_held <= next_w_held;
    w_byte <= next_w_byte;
    w_lane <= next_w_lane;
    bvalid <= next_bvalid;
    bresp <= next_bresp;
    rvalid <= next_rvalid;
    rdata <= next_rdata;
    rresp <= next_rresp;
    press_en <= next_press_en;
    temp_en <= next_temp_en;
    pmode <= next_pmode;
    osr_p <= next_osr_p;
    osr_t <= next_osr_t;
    filt_code <= next_filt_code;
    seed_p <= next_seed_p;
    seed_t <= next_seed_t;
    press_data <= next_press_data;
    temp_data <= next_temp_data;
    state <= next_state;
    cnt <= next_cnt;
    req <= next_req;
    conv <= next_conv;
  end

endmodule // oim_filter

// ### core/oim_pkg.sv
/*
  Types of the oversampled IIR measurement block.
  Assumes oim_consts.svh for all numeric constants.
*/
package oim_pkg;

  // Sequencer states.
  typedef enum logic [1:0] {ST_IDLE, ST_MEAS, ST_STANDBY} oim_state_t;

  // One conversion request as handed to the converter.
  typedef struct packed {
    logic do_press;
    logic do_temp;
    logic [2:0] osr_p;
    logic [2:0] osr_t;
  } oim_conv_t;

endpackage

// ### testbench/oim_conv_model.sv
/*
  Converter model: answers each request after a chosen latency.
  Assumes requests stay up until the done pulse is sampled.
*/
`timescale 1ns/10ps

module oim_conv_model (
  input wire logic aclk,
  input wire logic conv_req,
  input wire logic [3:0] lat,
  input wire logic [23:0] press_val,
  input wire logic [23:0] temp_val,
  output logic conv_done,
  output logic [23:0] raw_press,
  output logic [23:0] raw_temp
);
  logic [3:0] cnt = 4'h0;
  initial conv_done = 1'b0;
  initial raw_press = 24'h00_0000;
  initial raw_temp = 24'h00_0000;
  // Results toggle outside the done cycle so stale data cannot pass.
  always @(posedge aclk) begin
    conv_done <= 1'b0;
    raw_press <= ~raw_press;
    raw_temp <= ~raw_temp;
    cnt <= 4'h0;
    if (conv_req && !conv_done) begin
      cnt <= cnt + 4'h1;
      if (cnt >= lat) begin
        conv_done <= 1'b1;
        raw_press <= press_val;
        raw_temp <= temp_val;
      end
    end
  end
endmodule // oim_conv_model

// ### testbench/oim_filter_props.sv
/*
  Checker of the oim_filter ports: register bus handshakes and converter link.
  Assumes the package and the constants header are compiled before it.
*/
`timescale 1ns/10ps
`include "oim_consts.svh"

module oim_filter_props import oim_pkg::*; #(
  parameter int STANDBY_CYCLES = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [`OIM_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [`OIM_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic conv_req,
  input wire oim_conv_t conv_cfg,
  input wire logic conv_done,
  input wire logic [23:0] raw_press,
  input wire logic [23:0] raw_temp
);
  // ****************************************************************
  // Properties.
  // ****************************************************************
  // One clock domain, so clock and reset are given once for all.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence done_seen;
    conv_req && conv_done;
  endsequence
  a_reset_quiet: assert property ($rose(aresetn) |-> !conv_req && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs busy right after reset");
  a_write_answer: assert property (aw_w_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_req_enabled: assert property ($rose(conv_req) |-> conv_cfg.do_press || conv_cfg.do_temp)
    else $error("request with no channel");
  a_cfg_steady: assert property (conv_req && !conv_done |=> conv_req && $stable(conv_cfg))
    else $error("request changed mid conversion");
  a_req_ends: assert property (done_seen |=> !conv_req [*2])
    else $error("request held after done");
endmodule // oim_filter_props

bind oim_filter oim_filter_props #(.STANDBY_CYCLES(STANDBY_CYCLES)) u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .conv_req(conv_req), .conv_cfg(conv_cfg), .conv_done(conv_done),
  .raw_press(raw_press), .raw_temp(raw_temp)
);

// ### testbench/tb.sv
/*
  Bench of oim_filter: bus tasks set modes and read filtered results.
  Assumes the converter model and the checker are compiled before it.
*/
`timescale 1ns/10ps
`include "oim_consts.svh"

module tb import oim_pkg::*; ();
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, d, sp, st;
  logic awready, wready, bvalid, arready, rvalid, conv_req, conv_done;
  logic [1:0] bresp, rresp, r;
  logic [23:0] raw_press, raw_temp, pv = 24'h00_0000, tv = 24'h00_0000;
  logic [3:0] lat = 4'h2;
  oim_conv_t conv_cfg;
  int error_cnt = 0, total_checks = 0, dones = 0, cyc = 0;
  always #50 aclk = ~aclk;
  oim_filter #(.STANDBY_CYCLES(4)) DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .conv_req(conv_req), .conv_cfg(conv_cfg), .conv_done(conv_done),
    .raw_press(raw_press), .raw_temp(raw_temp));
  oim_conv_model u_conv (.aclk(aclk), .conv_req(conv_req), .lat(lat), .press_val(pv),
    .temp_val(tv), .conv_done(conv_done), .raw_press(raw_press), .raw_temp(raw_temp));
  // ****************************************************************
  // Tasks.
  // ****************************************************************
  // Each access starts one edge later, so no signal is assigned twice per step.
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Starts one measurement and returns both data registers.
  task automatic meas(input logic [31:0] c, input logic [23:0] p, input logic [23:0] t);
    int n;
    n = dones;
    pv <= p;
    tv <= t;
    wr(`OIM_REG_POWER_CONTROL, c, r);
    wait (dones > n);
    rd(`OIM_REG_PRESS_DATA, sp, r);
    rd(`OIM_REG_TEMP_DATA, st, r);
  endtask
  function automatic logic [31:0] m(input logic [23:0] v, input int o);
    return {8'h00, v & ~((24'h00_0001 << (8 - o)) - 24'h00_0001)};
  endfunction
  // Coefficient two to the k minus one; a 64-bit product keeps the weighted sum exact.
  function automatic logic [31:0] f(input logic [23:0] o, input logic [23:0] w, input int k);
    return {8'h00, 24'((64'(o) * ((64'h1 << k) - 64'h1) + 64'(w)) / (64'h1 << k))};
  endfunction
  task automatic test_done;
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (conv_req && conv_done) dones++;
    if (cyc == 3000) begin
      error_cnt++;
      test_done;
    end
  end
  // ****************************************************************
  // Sequence.
  // ****************************************************************
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OIM_REG_POWER_CONTROL, d, r);
    chk("ctrl reset", d, 32'h0000_0000);
    rd(8'h18, d, r);
    chk("unmapped resp", {30'h0, r}, 32'h0000_0002);
    wr(`OIM_REG_STATUS, 32'h0000_0001, r);
    chk("ro write resp", {30'h0, r}, 32'h0000_0002);
    for (int i = 0; i < 6; i++) begin
      wr(`OIM_REG_OSR, 32'(i << 3), r);
      meas(i[0] ? 32'h0000_0023 : 32'h0000_0013, 24'h12_3456, 24'hab_cdef - 24'(i));
      chk("press osr", sp, m(24'h12_3456, 0));
      chk("temp osr", st, m(24'hab_cdef - 24'(i), i));
      rd(`OIM_REG_POWER_CONTROL, d, r);
      chk("forced back", d, 32'h0000_0003);
    end
    for (int k = 1; k < 8; k++) begin
      wr(`OIM_REG_CONFIG, 32'(k << 1), r);
      chk("cfg write resp", {30'h0, r}, 32'h0000_0000);
      rd(`OIM_REG_STATUS, d, r);
      chk("seeds pending", d, 32'h0000_0006);
      meas(32'h0000_0013, 24'h80_0000, 24'h10_0000);
      chk("press seed", sp, 32'h0080_0000);
      meas(32'h0000_0013, 24'h20_0f00, 24'hf0_0000);
      chk("press iir", sp, f(24'h80_0000, 24'h20_0f00, k));
      chk("temp iir", st, f(24'h10_0000, 24'hf0_0000, k));
    end
    meas(32'h0000_0011, 24'h40_0000, 24'h33_3300);
    chk("press after fall", sp, 32'h0040_0000);
    chk("temp skipped", st, f(24'h10_0000, 24'hf0_0000, 7));
    meas(32'h0000_0013, 24'h00_0000, 24'h55_5500);
    chk("press kept", sp, f(24'h40_0000, 24'h00_0000, 7));
    chk("temp reenable", st, 32'h0055_5500);
    lat <= 4'h9;
    wr(`OIM_REG_OSR, 32'h0000_000c, r);
    meas(32'h0000_0033, 24'h66_6666, 24'h77_7777);
    chk("normal seed", sp, m(24'h66_6666, 4));
    chk("normal temp seed", st, m(24'h77_7777, 1));
    wr(`OIM_REG_POWER_CONTROL, 32'h0000_0003, r);
    test_done;
  end
endmodule // tb
